// >>> logic/sram_cycle_ctrl.sv
// cycle decode, burst sequencing and data lane control of a pipelined burst sram
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module sram_cycle_ctrl
  import sram_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES = LANES_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // bus control
  input wire logic chip_sel1_n,
  input wire logic chip_sel2,
  input wire logic chip_sel3_n,
  input wire logic advance_load_select,
  input wire logic write_strobe_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic out_enable_n,
  input wire logic clock_qualify_n,
  input wire logic sleep_request,
  input wire logic burst_order,
  input wire logic [ADDR_W-1:0] addr,
  // data and parity lanes
  input wire logic [LANES*LANE_BITS-1:0] data_in,
  input wire logic [LANES-1:0] parity_io_lanes_in,
  output logic [LANES*LANE_BITS-1:0] data_out,
  output logic [LANES-1:0] parity_io_lanes_out,
  output logic lane_oe,
  // array read port
  output logic array_rd_en,
  output logic [ADDR_W-1:0] array_rd_addr,
  input wire logic [LANES*(LANE_BITS+1)-1:0] array_rd_data,
  // array write port, fed from the write queue
  output logic array_wr_valid,
  output logic [ADDR_W-1:0] array_wr_addr,
  output logic [LANES-1:0] array_wr_lane_mask,
  output logic [LANES*(LANE_BITS+1)-1:0] array_wr_data,
  input wire logic array_wr_ready,
  // status
  output logic queue_full,
  output logic write_dropped,
  output logic snooze_active,
  output cycle_t cycle_kind
);

  localparam int DW = LANES * (LANE_BITS + 1);
  localparam int FW = ADDR_W + LANES + DW;

  initial begin
    if (ADDR_W < BURST_LOW_W + 1 || LANES < 1 || FIFO_DEPTH < 2) begin
      $error("sram_cycle_ctrl parameters out of range");
    end
  end

  // ----------------------------------------------------------------
  // burst address sequencing
  // ----------------------------------------------------------------
  function automatic logic [1:0] burst_low(input logic [1:0] first, input logic [1:0] beat, input logic order);
    if (order == BURST_ORDER_LINEAR) begin
      burst_low = first + beat;
    end else begin
      burst_low = first ^ beat;
    end
  endfunction

  function automatic logic is_read(input cycle_t k);
    is_read = (k == CYC_READ) || (k == CYC_DUMMY_READ);
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic cs_all;
  logic qual;
  logic blocked;
  logic cmd_ok;
  logic [1:0] recover_cnt_reg;
  logic [1:0] entry_cnt_reg;
  logic sleep_prev_reg;
  burst_t burst_reg;
  logic [ADDR_W-1:0] base_reg;
  logic [1:0] beat_reg;
  cycle_t p1_kind_reg;
  logic [ADDR_W-1:0] p1_addr_reg;
  logic [LANES-1:0] p1_lanes_reg;
  cycle_t p2_kind_reg;
  logic [ADDR_W-1:0] p2_addr_reg;
  logic [LANES-1:0] p2_lanes_reg;
  logic drive_pending_reg;
  logic drive_next;
  logic [LANES*LANE_BITS-1:0] data_out_reg;
  logic [LANES-1:0] parity_out_reg;
  logic lane_oe_reg;
  logic array_rd_en_reg;
  logic [ADDR_W-1:0] array_rd_addr_reg;
  logic write_dropped_reg;
  logic snooze_reg;
  cycle_t cycle_kind_reg;
  logic push;

  cycle_t dec_kind;
  burst_t dec_burst;
  logic [ADDR_W-1:0] dec_addr;
  logic [ADDR_W-1:0] dec_base;
  logic [1:0] dec_beat;
  logic [1:0] next_beat;

  assign cs_all = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
  assign qual = clk_en & ~clock_qualify_n;
  // recovery keeps commands out; the controller must hold selects off anyway
  assign blocked = sleep_request | (recover_cnt_reg != 2'h0);
  assign cmd_ok = qual & ~blocked;
  assign next_beat = beat_reg + BEAT_STEP;

  always_comb begin
    dec_kind = CYC_DESELECT;
    dec_burst = BURST_NONE;
    dec_base = base_reg;
    dec_beat = next_beat;
    dec_addr = {base_reg[ADDR_W-1:BURST_LOW_W], burst_low(base_reg[1:0], next_beat, burst_order)};
    if (!advance_load_select) begin
      dec_base = addr;
      dec_beat = BEAT_FIRST;
      dec_addr = addr;
      if (!cs_all) begin
        dec_kind = CYC_DESELECT;
      end else if (write_strobe_n) begin
        dec_burst = BURST_READ;
        dec_kind = out_enable_n ? CYC_DUMMY_READ : CYC_READ;
      end else begin
        dec_burst = BURST_WRITE;
        dec_kind = (&byte_lane_write_n) ? CYC_WRITE_ABORT : CYC_WRITE;
      end
    end else begin
      // selects and strobe are ignored while a burst continues
      case (burst_reg)
        BURST_READ: begin
          dec_burst = BURST_READ;
          dec_kind = out_enable_n ? CYC_DUMMY_READ : CYC_READ;
        end
        BURST_WRITE: begin
          dec_burst = BURST_WRITE;
          dec_kind = (&byte_lane_write_n) ? CYC_WRITE_ABORT : CYC_WRITE;
        end
        default: begin
          dec_kind = CYC_DESELECT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // burst state and first pipeline stage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      burst_reg <= BURST_NONE;
      base_reg <= '0;
      beat_reg <= BEAT_FIRST;
      p1_kind_reg <= CYC_DESELECT;
      p1_addr_reg <= '0;
      p1_lanes_reg <= '0;
    end else if (clk_en && blocked) begin
      burst_reg <= BURST_NONE;
      p1_kind_reg <= CYC_DESELECT;
    end else if (cmd_ok) begin
      burst_reg <= dec_burst;
      base_reg <= dec_base;
      beat_reg <= dec_beat;
      p1_kind_reg <= dec_kind;
      p1_addr_reg <= dec_addr;
      p1_lanes_reg <= ~byte_lane_write_n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      array_rd_en_reg <= 1'b0;
      array_rd_addr_reg <= '0;
    end else if (clk_en && blocked) begin
      array_rd_en_reg <= 1'b0;
    end else if (cmd_ok) begin
      array_rd_en_reg <= is_read(dec_kind);
      array_rd_addr_reg <= dec_addr;
    end
  end

  // ----------------------------------------------------------------
  // second stage: read data out, write data in
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      p2_kind_reg <= CYC_DESELECT;
      p2_addr_reg <= '0;
      p2_lanes_reg <= '0;
    end else if (clk_en && sleep_request) begin
      p2_kind_reg <= CYC_DESELECT;
    end else if (qual) begin
      p2_kind_reg <= p1_kind_reg;
      p2_addr_reg <= p1_addr_reg;
      p2_lanes_reg <= p1_lanes_reg;
    end
  end

  // a read of a word still waiting in the queue returns the older array contents
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      drive_pending_reg <= 1'b0;
      data_out_reg <= '0;
      parity_out_reg <= '0;
    end else if (clk_en && sleep_request) begin
      drive_pending_reg <= 1'b0;
    end else if (qual) begin
      drive_pending_reg <= is_read(p1_kind_reg);
      if (is_read(p1_kind_reg)) begin
        for (int i = 0; i < LANES; i++) begin
          data_out_reg[i*LANE_BITS +: LANE_BITS] <= array_rd_data[i*(LANE_BITS+1) +: LANE_BITS];
          parity_out_reg[i] <= array_rd_data[i*(LANE_BITS+1) + LANE_BITS];
        end
      end
    end
  end

  always_comb begin
    drive_next = drive_pending_reg;
    if (sleep_request) begin
      drive_next = 1'b0;
    end else if (qual) begin
      drive_next = is_read(p1_kind_reg) && (p1_kind_reg != CYC_WRITE);
    end
  end

  // output enable is sampled every enabled edge, stalls included, so it is never frozen
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lane_oe_reg <= 1'b0;
    end else if (clk_en) begin
      lane_oe_reg <= drive_next & ~out_enable_n;
    end
  end

  // ----------------------------------------------------------------
  // write queue
  // ----------------------------------------------------------------
  stream_if #(.W(FW)) wq ();
  logic [DW-1:0] wr_word;

  always_comb begin
    wr_word = '0;
    for (int i = 0; i < LANES; i++) begin
      wr_word[i*(LANE_BITS+1) +: LANE_BITS] = data_in[i*LANE_BITS +: LANE_BITS];
      wr_word[i*(LANE_BITS+1) + LANE_BITS] = parity_io_lanes_in[i];
    end
  end

  assign push = qual & ~sleep_request & (p2_kind_reg == CYC_WRITE);
  assign wq.in_valid = push;
  assign wq.in_data = {p2_addr_reg, p2_lanes_reg, wr_word};
  assign wq.out_ready = array_wr_ready;

  write_queue #(.W(FW), .DEPTH(FIFO_DEPTH)) u_queue (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .s(wq)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      write_dropped_reg <= 1'b0;
    end else if (clk_en && push && !wq.in_ready) begin
      write_dropped_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sleep entry and recovery
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      entry_cnt_reg <= 2'h0;
      recover_cnt_reg <= 2'h0;
      sleep_prev_reg <= 1'b0;
      snooze_reg <= 1'b0;
    end else if (clk_en) begin
      sleep_prev_reg <= sleep_request;
      if (sleep_request) begin
        recover_cnt_reg <= 2'h0;
        if (entry_cnt_reg != SLEEP_ENTRY_CYCLES) begin
          entry_cnt_reg <= entry_cnt_reg + 2'h1;
        end
        if (entry_cnt_reg == SLEEP_ENTRY_CYCLES - 2'h1) begin
          snooze_reg <= 1'b1;
        end
      end else begin
        entry_cnt_reg <= 2'h0;
        if (sleep_prev_reg) begin
          recover_cnt_reg <= SLEEP_EXIT_CYCLES;
        end else if (recover_cnt_reg != 2'h0) begin
          recover_cnt_reg <= recover_cnt_reg - 2'h1;
        end
        if (!sleep_prev_reg && recover_cnt_reg == 2'h1) begin
          snooze_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cycle_kind_reg <= CYC_DESELECT;
    end else if (clk_en) begin
      if (sleep_request) begin
        cycle_kind_reg <= CYC_SNOOZE;
      end else if (clock_qualify_n) begin
        cycle_kind_reg <= CYC_STALL;
      end else if (blocked) begin
        cycle_kind_reg <= CYC_DESELECT;
      end else begin
        cycle_kind_reg <= dec_kind;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign data_out = data_out_reg;
  assign parity_io_lanes_out = parity_out_reg;
  assign lane_oe = lane_oe_reg;
  assign array_rd_en = array_rd_en_reg;
  assign array_rd_addr = array_rd_addr_reg;
  assign array_wr_valid = wq.out_valid;
  assign array_wr_addr = wq.out_data[FW-1 -: ADDR_W];
  assign array_wr_lane_mask = wq.out_data[DW +: LANES];
  assign array_wr_data = wq.out_data[DW-1:0];
  assign queue_full = ~wq.in_ready;
  assign write_dropped = write_dropped_reg;
  assign snooze_active = snooze_reg;
  assign cycle_kind = cycle_kind_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_reset_floats: assert property (@(posedge ref_clk) disable iff (1'b0)
    srst |=> (!lane_oe && cycle_kind == CYC_DESELECT))
    else $error("lanes or cycle not idle after reset");

  a_read_start: assert property (
    cmd_ok && !advance_load_select && cs_all && write_strobe_n |=> array_rd_en && array_rd_addr == $past(addr))
    else $error("read start did not issue the pin address");

  a_read_continue: assert property (
    cmd_ok && advance_load_select && burst_reg == BURST_READ
    |=> array_rd_en && array_rd_addr[1:0] == burst_low($past(base_reg[1:0]), $past(next_beat), $past(burst_order)))
    else $error("read continuation address wrong");

  a_oe_gates_drive: assert property (
    clk_en && out_enable_n |=> !lane_oe)
    else $error("lanes driven with output enable inactive");

  a_stall_holds: assert property (
    clk_en && clock_qualify_n && !blocked |=> $stable(p1_kind_reg) && $stable(base_reg) && $stable(beat_reg))
    else $error("stalled edge changed state");

  a_write_capture: assert property (
    p1_kind_reg == CYC_WRITE && qual && !sleep_request ##1 qual && !sleep_request
    |-> push && wq.in_data[DW-1:0] == wr_word)
    else $error("write data not taken on the second qualified rise");

  a_abort_no_push: assert property (
    p2_kind_reg == CYC_WRITE_ABORT |-> !push)
    else $error("aborted write reached the queue");

  a_write_no_drive: assert property (
    p2_kind_reg == CYC_WRITE && !sleep_prev_reg |-> !lane_oe)
    else $error("lanes driven in a write data cycle");

  a_sleep_floats: assert property (
    clk_en && sleep_request |=> !lane_oe && !array_rd_en)
    else $error("lanes driven while sleeping");

  a_deselect_start: assert property (
    cmd_ok && !advance_load_select && !cs_all |=> p1_kind_reg == CYC_DESELECT && !array_rd_en)
    else $error("deselect did not idle the pipeline");

  c_read_burst: cover property (cmd_ok && !advance_load_select && cs_all && write_strobe_n ##1 cmd_ok && advance_load_select);
  c_write_push: cover property (push && wq.in_ready);
  c_stall: cover property (clk_en && clock_qualify_n && drive_pending_reg);
  c_snooze: cover property (snooze_active ##1 !sleep_request);

endmodule // sram_cycle_ctrl

// >>> logic/sram_pkg.sv
// shared constants and types for the pipelined burst sram cycle control
package sram_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W_DEF = 17;
  localparam int LANES_DEF = 4;
  localparam int LANE_BITS = 8;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam int BURST_LOW_W = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  // sleep entry and exit are both two clock periods
  localparam int SLEEP_ENTRY_PS = 2 * CLK_PERIOD_PS;
  localparam int SLEEP_EXIT_PS = 2 * CLK_PERIOD_PS;
  localparam logic [1:0] SLEEP_ENTRY_CYCLES = 2'((SLEEP_ENTRY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [1:0] SLEEP_EXIT_CYCLES = 2'((SLEEP_EXIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic BURST_ORDER_LINEAR = 1'b0;
  localparam logic [1:0] BEAT_FIRST = 2'h0;
  localparam logic [1:0] BEAT_STEP = 2'h1;

  typedef enum logic [2:0] {
    CYC_DESELECT,
    CYC_READ,
    CYC_DUMMY_READ,
    CYC_WRITE,
    CYC_WRITE_ABORT,
    CYC_STALL,
    CYC_SNOOZE
  } cycle_t;

  typedef enum logic [1:0] {
    BURST_NONE,
    BURST_READ,
    BURST_WRITE
  } burst_t;

endpackage

// >>> logic/stream_if.sv
// valid/ready carrier between the cycle control and its write queue
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fill (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
  modport store (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
endinterface

// >>> logic/write_queue.sv
// parameterised fifo with a registered output stage
`timescale 1ns/1ps
module write_queue #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // clock and control
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  // stream
  stream_if.store s
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("write_queue depth must be a power of two of at least 2");
    end
  end

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [PW:0] count_reg;
  logic [PW:0] count_next;
  logic full_reg;
  logic out_valid_reg;
  logic [W-1:0] out_data_reg;
  logic push;
  logic pop;

  assign push = s.in_valid & ~full_reg;
  assign pop = (count_reg != '0) & (~out_valid_reg | s.out_ready);
  assign s.in_ready = ~full_reg;
  assign s.out_valid = out_valid_reg;
  assign s.out_data = out_data_reg;

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      mem[wptr_reg] <= s.in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
    end else if (clk_en) begin
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop) rptr_reg <= rptr_reg + 1'b1;
      count_reg <= count_next;
      full_reg <= (count_next == DEPTH_C);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else if (clk_en) begin
      if (pop) begin
        out_valid_reg <= 1'b1;
        out_data_reg <= mem[rptr_reg];
      end else if (s.out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

endmodule // write_queue

// >>> tb/array_model.sv
// behavioural storage array standing on the far side of the cycle control
`timescale 1ns/1ps
module array_model (
  // clock
  input wire logic ref_clk,
  input wire logic clk_en,
  // read port
  input wire logic [16:0] array_rd_addr,
  output logic [35:0] array_rd_data,
  // write port
  input wire logic array_wr_valid,
  input wire logic [16:0] array_wr_addr,
  input wire logic [3:0] array_wr_lane_mask,
  input wire logic [35:0] array_wr_data,
  input wire logic hold,
  output logic array_wr_ready
);
  // only sixteen words: the bench never needs more, and it keeps the model cheap
  logic [35:0] mem [16];
  assign array_rd_data = mem[array_rd_addr[3:0]];
  // hold lets the bench stall the consumer so the queue backs up
  assign array_wr_ready = ~hold;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 36'h0;
  end
  always @(posedge ref_clk) begin
    if (array_wr_valid && array_wr_ready && clk_en) begin
      for (int l = 0; l < 4; l++) begin
        if (array_wr_lane_mask[l]) mem[array_wr_addr[3:0]][9*l +: 9] <= array_wr_data[9*l +: 9];
      end
    end
  end
endmodule // array_model

// >>> tb/pipelined_burst_sram_cycle_control_tb.sv
// self-checking bench for the pipelined burst sram cycle control
`timescale 1ns/1ps
module pipelined_burst_sram_cycle_control_tb;
  import sram_pkg::*;
  logic ref_clk = 0, srst = 1, clk_en = 1, chip_sel1_n = 0, chip_sel2 = 0, chip_sel3_n = 0;
  logic advance_load_select = 0, write_strobe_n = 1, out_enable_n = 0, clock_qualify_n = 0;
  logic sleep_request = 0, burst_order = 0, hold = 0, lane_oe, array_rd_en, array_wr_valid, array_wr_ready;
  logic queue_full, write_dropped, snooze_active;
  logic [3:0] byte_lane_write_n = 4'hF, parity_io_lanes_in = 4'h0, parity_io_lanes_out, array_wr_lane_mask;
  logic [16:0] addr = 17'h0, array_rd_addr, array_wr_addr;
  logic [31:0] data_in = 32'h0, data_out;
  logic [35:0] array_rd_data, array_wr_data;
  cycle_t cycle_kind;
  int miscompares = 0, compares = 0;

  sram_cycle_ctrl u_dut (.ref_clk, .srst, .clk_en, .chip_sel1_n, .chip_sel2, .chip_sel3_n,
    .advance_load_select, .write_strobe_n, .byte_lane_write_n, .out_enable_n, .clock_qualify_n,
    .sleep_request, .burst_order, .addr, .data_in, .parity_io_lanes_in, .data_out, .parity_io_lanes_out,
    .lane_oe, .array_rd_en, .array_rd_addr, .array_rd_data, .array_wr_valid, .array_wr_addr,
    .array_wr_lane_mask, .array_wr_data, .array_wr_ready, .queue_full, .write_dropped, .snooze_active,
    .cycle_kind);
  array_model u_array (.ref_clk, .clk_en, .array_rd_addr, .array_rd_data, .array_wr_valid, .array_wr_addr,
    .array_wr_lane_mask, .array_wr_data, .hold, .array_wr_ready);

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // idle lanes carry a changing pattern so a stale value is never mistaken for data
  task automatic drv(input logic s, input logic a, input logic w, input logic [3:0] b, input logic [16:0] ad,
                     input logic [35:0] d);
    @(posedge ref_clk);
    chip_sel2 <= s;
    advance_load_select <= a;
    write_strobe_n <= w;
    byte_lane_write_n <= b;
    addr <= ad;
    {parity_io_lanes_in, data_in} <= d;
  endtask
  task automatic idle();
    drv(0, 0, 1, 4'hF, addr, ~{parity_io_lanes_in, data_in});
    #1;
  endtask
  task automatic wait_wr(input logic v);
    for (int i = 0; i < 100; i++) begin
      if (array_wr_valid === v) return;
      idle();
    end
    miscompares++;
    report_and_stop();
  endtask
  task automatic wr(input logic [16:0] ad, input logic [3:0] b, input logic [35:0] d);
    drv(1, 0, 0, b, ad, ~d);
    drv(0, 0, 1, 4'hF, ad, d);
    #1;
    chk(36'(cycle_kind), 36'(b == 4'hF ? CYC_WRITE_ABORT : CYC_WRITE));
    // data must stand at the second rise after the command
    drv(0, 0, 1, 4'hF, ad, d);
    #1;
    chk(36'(lane_oe), 36'h0);
  endtask
  task automatic rd(input logic [16:0] ad, input cycle_t k, input logic oe, input logic [35:0] e);
    drv(1, 0, 1, 4'hF, ad, ~{parity_io_lanes_in, data_in});
    idle();
    chk(36'(cycle_kind), 36'(k));
    idle();
    chk(36'(lane_oe), 36'(oe));
    if (oe) chk({parity_io_lanes_out, data_out}, e);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 0;
    idle();
    chk(36'(lane_oe), 36'h0);
    chk(36'(cycle_kind), 36'(CYC_DESELECT));
    $display("test reset done");
    wr(17'h4, 4'h0, 36'h5A1B2C3D4);
    wait_wr(1);
    wait_wr(0);
    wr(17'h4, 4'hD, 36'hAFFEEDDCC);
    wait_wr(1);
    chk(36'(array_wr_lane_mask), 36'h2);
    wait_wr(0);
    rd(17'h4, CYC_READ, 1, 36'h7A1B2DDD4);
    $display("test lane writes done");
    @(posedge ref_clk);
    out_enable_n <= 1;
    rd(17'h4, CYC_DUMMY_READ, 0, 36'h0);
    @(posedge ref_clk);
    out_enable_n <= 0;
    wr(17'h8, 4'hF, 36'h0);
    repeat (3) idle();
    chk(36'(array_wr_valid), 36'h0);
    $display("test dummy and abort done");
    @(posedge ref_clk);
    clock_qualify_n <= 1;
    @(posedge ref_clk);
    #1;
    chk(36'(cycle_kind), 36'(CYC_STALL));
    @(posedge ref_clk);
    clock_qualify_n <= 0;
    $display("test stall done");
    for (int o = 0; o < 2; o++) begin
      @(posedge ref_clk);
      burst_order <= o[0];
      drv(1, 0, 1, 4'hF, 17'h1, 36'h0);
      drv(0, 1, 0, 4'hF, 17'h1F, 36'h0);
      idle();
      chk(36'(array_rd_addr), o ? 36'h0 : 36'h2);
      chk(36'(cycle_kind), 36'(CYC_READ));
    end
    $display("test burst order done");
    @(posedge ref_clk);
    sleep_request <= 1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(36'(snooze_active), 36'h1);
    chk(36'(lane_oe), 36'h0);
    @(posedge ref_clk);
    sleep_request <= 0;
    repeat (4) idle();
    chk(36'(snooze_active), 36'h0);
    $display("test sleep done");
    @(posedge ref_clk);
    hold <= 1;
    drv(1, 0, 0, 4'h0, 17'h0, 36'h0);
    repeat (40) drv(0, 1, 1, 4'h0, 17'h0, ~{parity_io_lanes_in, data_in});
    #1;
    chk(36'(queue_full), 36'h1);
    chk(36'(write_dropped), 36'h1);
    @(posedge ref_clk);
    hold <= 0;
    wait_wr(0);
    $display("test queue fill done");
    report_and_stop();
  end
endmodule // pipelined_burst_sram_cycle_control_tb
